// ===== drss_sequencer.sv
/*
  Run-command sequencer: output block, timed wait, speed-search restart,
  and the six-mode automatic step program with step-equal outputs.
  Assumes pins arrive asynchronously; settings are quasi-static levels
  from the same clock domain.
*/
// Behaviour
// R1 - Block input active disables output, motor coasts
// R2 - After block input, wait block time, restart
// R3 - Voltage alarm with restart option disables output
// R4 - Voltage normal again, wait block time, restart
// R5 - Type 0: no search, start frequency
// R6 - Search from previous, upper limit, or set
// R7 - Search begins at chosen frequency, zero volts
// R8 - Raise voltage at rate until stall current
// R9 - Lower frequency and voltage until current drops
// R10 - Then ramp normally to target frequency
// R11 - Step periods: jog, three presets, fifth period
// R12 - Mode 1: four steps then main speed
// R13 - Mode 2: four steps, halt, repeat
// R14 - Mode 3: halt, reverse, five steps, repeat
// R15 - Mode 4: like 2, main speed step 5
// R16 - Mode 5: like 3, main speed steps 5,10
// R17 - Mode 6: like 4, loop from step 2
// R18 - Step-equal outputs active only during matching step
// R19 - Mode 0: sequencer idle, outputs inactive
`timescale 1ns/100ps
`default_nettype none
module drss_sequencer #(
  parameter int TICK_CYC = drss_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic block_pin,
  input wire logic undervoltage_alarm,
  input wire logic overvoltage_alarm,
  input wire logic run_cmd,
  input wire logic voltage_alarm_restart_enable,
  input wire logic [1:0] restart_type,
  input wire logic [drss_pkg::CUR_W-1:0] output_current,
  input wire logic [drss_pkg::CUR_W-1:0] restart_stall_level,
  input wire logic [drss_pkg::FREQ_W-1:0] restart_decel_rate,
  input wire logic [drss_pkg::VOLT_W-1:0] voltage_recover_rate,
  input wire logic [drss_pkg::VOLT_W-1:0] target_voltage,
  input wire logic [drss_pkg::FREQ_W-1:0] running_frequency,
  input wire logic [drss_pkg::FREQ_W-1:0] starting_frequency,
  input wire logic [drss_pkg::FREQ_W-1:0] upper_limit_frequency,
  input wire logic [drss_pkg::FREQ_W-1:0] set_frequency,
  input wire logic [drss_pkg::TIME_W-1:0] block_wait_time,
  input wire logic [2:0] auto_mode_select,
  input wire logic [drss_pkg::TIME_W-1:0] jog_step_period,
  input wire logic [drss_pkg::TIME_W-1:0] preset_one_step_period,
  input wire logic [drss_pkg::TIME_W-1:0] preset_two_step_period,
  input wire logic [drss_pkg::TIME_W-1:0] preset_three_step_period,
  input wire logic [drss_pkg::TIME_W-1:0] main_or_halt_step_period,
  input wire logic [6:0] digital_output_function_select [drss_pkg::NUM_DO],
  output logic output_enable_ff,
  output logic search_active_ff,
  output logic ramp_release_ff,
  output logic [drss_pkg::FREQ_W-1:0] search_frequency_ff,
  output logic [drss_pkg::VOLT_W-1:0] search_voltage_ff,
  output logic [2:0] speed_select_ff,
  output logic reverse_ff,
  output logic [3:0] auto_step_ff,
  output logic [drss_pkg::NUM_DO-1:0] step_equal_out_ff
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic block_in;
  logic volt_alarm;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end else begin
      sync1_ff <= {overvoltage_alarm, undervoltage_alarm, block_pin};
      sync2_ff <= sync1_ff;
    end
  end

  assign block_in = sync2_ff[0];
  assign volt_alarm = sync2_ff[1] | sync2_ff[2];

  // ---------------------------------------------------------------
  // Restart state machine
  // ---------------------------------------------------------------
  drss_pkg::drss_rs_type rs_ff;
  logic [drss_pkg::TIME_W-1:0] wait_cnt_ff;
  logic block_cause;
  logic [drss_pkg::FREQ_W-1:0] start_freq;

  // Alarm only blocks when the option is on and the drive runs
  assign block_cause = block_in |
    (volt_alarm & voltage_alarm_restart_enable &
     (rs_ff == drss_pkg::RS_RUN) & run_cmd); // see R3

  always_comb begin
    unique case (restart_type) // see R6
      drss_pkg::RST_PREV: start_freq = running_frequency;
      drss_pkg::RST_UPPER: start_freq = upper_limit_frequency;
      drss_pkg::RST_SET: start_freq = set_frequency;
      default: start_freq = starting_frequency; // see R5
    endcase
  end

  function automatic logic [drss_pkg::FREQ_W-1:0] sat_sub(
    input logic [drss_pkg::FREQ_W-1:0] a,
    input logic [drss_pkg::FREQ_W-1:0] b
  );
    sat_sub = (a > b) ? a - b : '0;
  endfunction

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rs_ff <= drss_pkg::RS_RUN;
      wait_cnt_ff <= '0;
      output_enable_ff <= 1'b1;
      search_active_ff <= 1'b0;
      ramp_release_ff <= 1'b0;
      search_frequency_ff <= '0;
      search_voltage_ff <= '0;
    end else begin
      ramp_release_ff <= 1'b0;
      unique case (rs_ff)
        drss_pkg::RS_RUN: begin
          if (block_cause) begin
            rs_ff <= drss_pkg::RS_BLOCK;
            output_enable_ff <= 1'b0; // see R1
          end
        end
        drss_pkg::RS_BLOCK: begin
          // Hold off while the block input or supply alarm persists
          if (!block_in && !volt_alarm) begin // see R2, R4
            rs_ff <= drss_pkg::RS_WAIT;
            wait_cnt_ff <= block_wait_time;
          end
        end
        drss_pkg::RS_WAIT: begin
          if (block_in || volt_alarm) begin
            rs_ff <= drss_pkg::RS_BLOCK;
          end else if (wait_cnt_ff != '0) begin
            wait_cnt_ff <= wait_cnt_ff - 1'b1; // see R2, R4
          end else if (restart_type == drss_pkg::RST_NONE) begin
            rs_ff <= drss_pkg::RS_RUN;
            output_enable_ff <= 1'b1;
            search_frequency_ff <= start_freq; // see R5
            ramp_release_ff <= 1'b1;
          end else begin
            rs_ff <= drss_pkg::RS_VRISE;
            output_enable_ff <= 1'b1;
            search_active_ff <= 1'b1;
            search_frequency_ff <= start_freq; // see R7
            search_voltage_ff <= '0; // see R7
          end
        end
        drss_pkg::RS_VRISE: begin
          if (block_in) begin
            rs_ff <= drss_pkg::RS_BLOCK;
            output_enable_ff <= 1'b0;
            search_active_ff <= 1'b0;
          end else if (output_current >= restart_stall_level) begin
            rs_ff <= drss_pkg::RS_DECEL; // see R8
          end else if (search_voltage_ff < target_voltage) begin
            search_voltage_ff <= search_voltage_ff + voltage_recover_rate;
          end
        end
        drss_pkg::RS_DECEL: begin
          if (block_in) begin
            rs_ff <= drss_pkg::RS_BLOCK;
            output_enable_ff <= 1'b0;
            search_active_ff <= 1'b0;
          end else if (output_current < restart_stall_level) begin
            rs_ff <= drss_pkg::RS_RUN; // see R9
            search_active_ff <= 1'b0;
            ramp_release_ff <= 1'b1; // see R10
          end else begin
            search_frequency_ff <=
              sat_sub(search_frequency_ff, restart_decel_rate); // see R9
            search_voltage_ff <=
              sat_sub(search_voltage_ff, restart_decel_rate); // see R9
          end
        end
        default: rs_ff <= drss_pkg::RS_RUN;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Auto step timebase
  // ---------------------------------------------------------------
  logic [31:0] tick_cnt_ff;
  logic tick;

  assign tick = (tick_cnt_ff == 32'(TICK_CYC - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_ff <= '0;
    end else if (tick || auto_step_ff == drss_pkg::STEP_IDLE) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // Auto step program
  // ---------------------------------------------------------------
  logic [drss_pkg::TIME_W-1:0] step_cnt_ff;
  logic auto_on;
  logic [3:0] nxt_step, nxt_auto_step;

  assign auto_on = (auto_mode_select != drss_pkg::AUTO_OFF) &&
    (auto_mode_select <= drss_pkg::AUTO_FROM_TWO) && run_cmd;

  function automatic logic [drss_pkg::TIME_W-1:0] step_period(
    input logic [3:0] s
  );
    logic [3:0] base;
    base = (s > 4'h5) ? s - 4'h5 : s;
    unique case (base) // see R11
      4'h1: step_period = jog_step_period;
      4'h2: step_period = preset_one_step_period;
      4'h3: step_period = preset_two_step_period;
      4'h4: step_period = preset_three_step_period;
      default: step_period = main_or_halt_step_period;
    endcase
  endfunction

  function automatic logic [2:0] step_speed(
    input logic [3:0] s,
    input logic [2:0] mode
  );
    logic [3:0] base;
    logic halt;
    base = (s > 4'h5) ? s - 4'h5 : s;
    halt = (mode == drss_pkg::AUTO_STOP_REP) ||
      (mode == drss_pkg::AUTO_STOP_REV); // see R13, R14
    unique case (base)
      4'h1: step_speed = drss_pkg::SEL_JOG;
      4'h2: step_speed = drss_pkg::SEL_PRE1;
      4'h3: step_speed = drss_pkg::SEL_PRE2;
      4'h4: step_speed = drss_pkg::SEL_PRE3;
      default: step_speed = halt ? drss_pkg::SEL_STOP : drss_pkg::SEL_MAIN;
    endcase
  endfunction

  // Successor step after the current one expires
  always_comb begin
    nxt_step = auto_step_ff + 4'h1;
    if (auto_step_ff == 4'h5) begin
      unique case (auto_mode_select)
        drss_pkg::AUTO_MAINTAIN: nxt_step = 4'h5; // see R12
        drss_pkg::AUTO_STOP_REP: nxt_step = 4'h1; // see R13
        drss_pkg::AUTO_MAIN_REP: nxt_step = 4'h1; // see R15
        drss_pkg::AUTO_FROM_TWO: nxt_step = 4'h2; // see R17
        default: nxt_step = 4'h6; // see R14, R16
      endcase
    end else if (auto_step_ff == 4'hA) begin
      nxt_step = 4'h1; // see R14, R16
    end
  end

  // Step taken at the coming edge; step outputs follow it
  assign nxt_auto_step = !auto_on ? drss_pkg::STEP_IDLE :
    (auto_step_ff == drss_pkg::STEP_IDLE) ? 4'h1 :
    (tick && step_cnt_ff <= 32'h1) ? nxt_step : auto_step_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      auto_step_ff <= drss_pkg::STEP_IDLE;
      step_cnt_ff <= '0;
      speed_select_ff <= drss_pkg::SEL_MAIN;
      reverse_ff <= 1'b0;
    end else if (!auto_on) begin
      auto_step_ff <= drss_pkg::STEP_IDLE; // see R19
      step_cnt_ff <= '0;
      speed_select_ff <= drss_pkg::SEL_MAIN;
      reverse_ff <= 1'b0;
    end else if (auto_step_ff == drss_pkg::STEP_IDLE) begin
      auto_step_ff <= 4'h1;
      step_cnt_ff <= step_period(4'h1);
      speed_select_ff <= drss_pkg::SEL_JOG;
      reverse_ff <= 1'b0;
    end else if (auto_step_ff == 4'h5 &&
                 auto_mode_select == drss_pkg::AUTO_MAINTAIN) begin
      speed_select_ff <= drss_pkg::SEL_MAIN; // see R12
    end else if (tick) begin
      if (step_cnt_ff > 32'h1) begin
        step_cnt_ff <= step_cnt_ff - 32'h1; // see R11
      end else begin
        auto_step_ff <= nxt_step;
        step_cnt_ff <= step_period(nxt_step);
        speed_select_ff <= step_speed(nxt_step, auto_mode_select);
        reverse_ff <= (nxt_step > 4'h5); // see R14, R16
      end
    end
  end

  // ---------------------------------------------------------------
  // Step-equal digital outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      step_equal_out_ff <= '0;
    end else begin
      for (int i = 0; i < drss_pkg::NUM_DO; i++) begin
        unique case (digital_output_function_select[i]) // see R18
          drss_pkg::DO_STEP2: step_equal_out_ff[i] <= (nxt_auto_step == 4'h2);
          drss_pkg::DO_STEP3: step_equal_out_ff[i] <= (nxt_auto_step == 4'h3);
          drss_pkg::DO_STEP4: step_equal_out_ff[i] <= (nxt_auto_step == 4'h4);
          default: step_equal_out_ff[i] <= 1'b0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_block_coasts: assert property (@(posedge clk) disable iff (!reset_n)
    block_in |=> ##1 !output_enable_ff) // see R1
    else $error("output not blocked while block input active");

  a_wait_holds: assert property (@(posedge clk) disable iff (!reset_n)
    (rs_ff == drss_pkg::RS_WAIT && wait_cnt_ff != '0) |=> !output_enable_ff)
    else $error("output enabled during block wait"); // see R2

  a_alarm_blocks: assert property (@(posedge clk) disable iff (!reset_n)
    (rs_ff == drss_pkg::RS_RUN && volt_alarm && run_cmd &&
     voltage_alarm_restart_enable) |=> !output_enable_ff) // see R3
    else $error("voltage alarm did not block output");

  a_search_zero_v: assert property (@(posedge clk) disable iff (!reset_n)
    ($rose(search_active_ff) |-> search_voltage_ff == '0)) // see R7
    else $error("search did not start at zero voltage");

  a_vrise_freq: assert property (@(posedge clk) disable iff (!reset_n)
    (rs_ff == drss_pkg::RS_VRISE ##1 rs_ff == drss_pkg::RS_VRISE) |->
    $stable(search_frequency_ff)) // see R8
    else $error("frequency moved during voltage rise");

  a_decel_exit: assert property (@(posedge clk) disable iff (!reset_n)
    (rs_ff == drss_pkg::RS_DECEL && !block_in &&
     output_current < restart_stall_level) |=> ramp_release_ff) // see R9, R10
    else $error("no ramp release at speed match");

  a_idle_mode: assert property (@(posedge clk) disable iff (!reset_n)
    (auto_mode_select == drss_pkg::AUTO_OFF) [*2] |->
    step_equal_out_ff == '0 && auto_step_ff == drss_pkg::STEP_IDLE)
    else $error("sequencer active in mode 0"); // see R19

  a_mode6_loop: assert property (@(posedge clk) disable iff (!reset_n)
    (auto_step_ff == 4'h5 && auto_mode_select == drss_pkg::AUTO_FROM_TWO &&
     $stable(auto_mode_select) && run_cmd ##1 auto_step_ff != 4'h5 &&
     $stable(auto_mode_select) && run_cmd) |-> auto_step_ff == 4'h2)
    else $error("mode 6 did not loop to step 2"); // see R17

  a_reverse_half: assert property (@(posedge clk) disable iff (!reset_n)
    (auto_step_ff > 4'h5) |-> reverse_ff) // see R14, R16
    else $error("second half not reversed");

endmodule
`default_nettype wire

// ===== drss_pkg.sv
/*
  Constants and types for the drive restart and auto step sequencer.
  Assumes a single 250 MHz clock domain; no register bus.
*/
package drss_pkg;

  // ---------------------------------------------------------------
  // Widths and timing
  // ---------------------------------------------------------------
  localparam int FREQ_W = 16;
  localparam int VOLT_W = 16;
  localparam int CUR_W = 16;
  localparam int TIME_W = 32;
  localparam int CLK_MHZ = 250;
  // Time base of period settings: one tick per millisecond
  localparam int TICK_NS = 1000000;
  localparam int CLK_NS = 4;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;

  // ---------------------------------------------------------------
  // Restart types and auto modes
  // ---------------------------------------------------------------
  localparam logic [1:0] RST_NONE = 2'h0;
  localparam logic [1:0] RST_PREV = 2'h1;
  localparam logic [1:0] RST_UPPER = 2'h2;
  localparam logic [1:0] RST_SET = 2'h3;

  localparam logic [2:0] AUTO_OFF = 3'h0;
  localparam logic [2:0] AUTO_MAINTAIN = 3'h1;
  localparam logic [2:0] AUTO_STOP_REP = 3'h2;
  localparam logic [2:0] AUTO_STOP_REV = 3'h3;
  localparam logic [2:0] AUTO_MAIN_REP = 3'h4;
  localparam logic [2:0] AUTO_MAIN_REV = 3'h5;
  localparam logic [2:0] AUTO_FROM_TWO = 3'h6;

  // Step-equal output function codes
  localparam logic [6:0] DO_STEP2 = 7'h16;
  localparam logic [6:0] DO_STEP3 = 7'h17;
  localparam logic [6:0] DO_STEP4 = 7'h18;
  localparam int NUM_DO = 3;

  // Speed command selection
  localparam logic [2:0] SEL_STOP = 3'h0;
  localparam logic [2:0] SEL_JOG = 3'h1;
  localparam logic [2:0] SEL_PRE1 = 3'h2;
  localparam logic [2:0] SEL_PRE2 = 3'h3;
  localparam logic [2:0] SEL_PRE3 = 3'h4;
  localparam logic [2:0] SEL_MAIN = 3'h5;

  localparam logic [3:0] STEP_IDLE = 4'h0;

  typedef enum logic [4:0] {
    RS_RUN = 5'b00001,
    RS_BLOCK = 5'b00010,
    RS_WAIT = 5'b00100,
    RS_VRISE = 5'b01000,
    RS_DECEL = 5'b10000
  } drss_rs_type;

endpackage

// ===== drss_motor_model.sv
/*
  Power stage and motor stand-in for the sequencer bench.
  Assumes the current input of the sequencer is fed from this model only.
*/
`timescale 1ns/100ps
`default_nettype none
module drss_motor_model (
  input wire logic clk,
  input wire logic output_enable,
  input wire logic search_active,
  input wire logic [drss_pkg::VOLT_W-1:0] search_voltage,
  output logic [drss_pkg::CUR_W-1:0] output_current
);
  // Coasting stage carries no current; in search current follows voltage
  always_ff @(posedge clk) begin
    if (!output_enable) output_current <= 16'h0000;
    else if (search_active) output_current <= search_voltage;
    else output_current <= 16'h0010;
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
/*
  Self-checking bench for the restart and auto step sequencer.
  Assumes the motor model on the current input and one 250 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // -------------------------------------------------------------
  // Signals and design
  // -------------------------------------------------------------
  localparam int TK = 4;
  logic clk, reset_n, block_pin, undervoltage_alarm, overvoltage_alarm;
  logic run_cmd, voltage_alarm_restart_enable;
  logic [1:0] restart_type;
  logic [2:0] auto_mode_select, speed_select_ff, step_equal_out_ff;
  logic [15:0] output_current, restart_stall_level, restart_decel_rate;
  logic [15:0] voltage_recover_rate, target_voltage, running_frequency;
  logic [15:0] starting_frequency, upper_limit_frequency, set_frequency;
  logic [31:0] block_wait_time, jog_step_period, preset_one_step_period;
  logic [31:0] preset_two_step_period, preset_three_step_period;
  logic [31:0] main_or_halt_step_period;
  logic [6:0] digital_output_function_select [drss_pkg::NUM_DO];
  logic [6:0] codes [4] = '{drss_pkg::DO_STEP2, drss_pkg::DO_STEP3,
                            drss_pkg::DO_STEP4, 7'h05};
  logic output_enable_ff, search_active_ff, ramp_release_ff, reverse_ff;
  logic [15:0] search_frequency_ff, search_voltage_ff, l_v, l_f, st_f;
  logic [3:0] auto_step_ff, l_step;
  logic l_srch;
  int fails, tests_run, seed, cnt;
  logic [7:0] q_step [$];
  logic [15:0] q_freq [$];

  drss_sequencer #(.TICK_CYC(TK)) uut (.clk, .reset_n, .block_pin,
    .undervoltage_alarm, .overvoltage_alarm, .run_cmd,
    .voltage_alarm_restart_enable, .restart_type, .output_current,
    .restart_stall_level, .restart_decel_rate, .voltage_recover_rate,
    .target_voltage, .running_frequency, .starting_frequency,
    .upper_limit_frequency, .set_frequency, .block_wait_time,
    .auto_mode_select, .jog_step_period, .preset_one_step_period,
    .preset_two_step_period, .preset_three_step_period,
    .main_or_halt_step_period, .digital_output_function_select,
    .output_enable_ff, .search_active_ff, .ramp_release_ff,
    .search_frequency_ff, .search_voltage_ff, .speed_select_ff,
    .reverse_ff, .auto_step_ff, .step_equal_out_ff);

  drss_motor_model motor (.clk, .output_enable(output_enable_ff),
    .search_active(search_active_ff), .search_voltage(search_voltage_ff),
    .output_current);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // -------------------------------------------------------------
  // Checking
  // -------------------------------------------------------------
  task automatic cmp_val(input logic [31:0] exp, input logic [31:0] act);
    tests_run++;
    if (act !== exp) begin
      fails++;
      $display("[ERR] t=%0t exp=%h act=%h", $time, exp, act);
    end
  endtask

  task automatic print_verdict;
    $display("Counts: tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  function automatic logic [2:0] se_of(input logic [3:0] s);
    logic [2:0] r;
    for (int i = 0; i < 3; i++)
      r[i] = s != 0 && {3'h0, s} == digital_output_function_select[i] - 7'h14;
    return r;
  endfunction

  function automatic logic [2:0] sel_of(input int s, input logic [2:0] m);
    case ((s - 1) % 5)
      0: return drss_pkg::SEL_JOG;
      1: return drss_pkg::SEL_PRE1;
      2: return drss_pkg::SEL_PRE2;
      3: return drss_pkg::SEL_PRE3;
      default: return (m == 3'h2 || m == 3'h3) ? drss_pkg::SEL_STOP :
                      drss_pkg::SEL_MAIN;
    endcase
  endfunction

  function automatic int nxt(input int s, input logic [2:0] m);
    if (s == 10) return 1;
    if (s != 5) return s + 1;
    if (m == 3'h3 || m == 3'h5) return 6;
    return m == 3'h6 ? 2 : 1;
  endfunction

  function automatic int per_of(input logic [3:0] s);
    case ((int'(s) + 4) % 5)
      0: return jog_step_period;
      1: return preset_one_step_period;
      2: return preset_two_step_period;
      3: return preset_three_step_period;
      default: return main_or_halt_step_period;
    endcase
  endfunction

  always @(posedge clk) begin
    logic [7:0] e;
    logic [7:0] a;
    int d;
    if (!reset_n) begin
      l_step = 4'h0;
      l_srch = 1'b0;
    end else begin
      cnt++;
      cmp_val(se_of(auto_step_ff), step_equal_out_ff);
      if (auto_step_ff !== l_step) begin
        e = q_step.size() ? q_step.pop_front() : 8'hFF;
        a = {auto_step_ff, speed_select_ff, reverse_ff};
        cmp_val(e, a);
        d = per_of(l_step) * TK;
        a = cnt >= d - 2 && cnt <= d + 2;
        if (l_step != 0 && auto_step_ff != 0) cmp_val(1, a);
        cnt = 0;
      end
      if (search_active_ff && !l_srch) begin
        st_f = q_freq.size() ? q_freq.pop_front() : 16'hFFFF;
        cmp_val(st_f, search_frequency_ff);
        cmp_val(0, search_voltage_ff);
      end else if (search_active_ff && search_frequency_ff == st_f &&
                   search_voltage_ff != l_v) begin
        cmp_val(l_v + voltage_recover_rate, search_voltage_ff);
      end else if (search_active_ff && search_frequency_ff != l_f) begin
        cmp_val(16'(l_f - restart_decel_rate), search_frequency_ff);
        cmp_val(16'(l_v - restart_decel_rate), search_voltage_ff);
      end
      if (ramp_release_ff && !l_srch) begin
        e = 0;
        st_f = q_freq.size() ? q_freq.pop_front() : 16'hFFFF;
        cmp_val(st_f, search_frequency_ff);
      end
      if (ramp_release_ff && l_srch) cmp_val(1, search_frequency_ff < st_f);
      l_step = auto_step_ff;
      l_srch = search_active_ff;
      l_v = search_voltage_ff;
      l_f = search_frequency_ff;
    end
  end

  // -------------------------------------------------------------
  // Stimulus
  // -------------------------------------------------------------
  task automatic wait_oe(input logic v, input int lim, output int n);
    n = 0;
    while (output_enable_ff !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic blk(input logic [1:0] t);
    int n;
    q_freq.push_back(t == 0 ? starting_frequency : t == 1 ? running_frequency
                     : t == 2 ? upper_limit_frequency : set_frequency);
    @(posedge clk);
    restart_type <= t;
    block_pin <= 1'b1;
    wait_oe(1'b0, 6, n);
    cmp_val(1, n <= 4);
    repeat (10) @(posedge clk);
    block_pin <= 1'b0;
    wait_oe(1'b1, 200, n);
    cmp_val(1, n >= block_wait_time && n <= block_wait_time + 6);
    repeat (300) @(posedge clk);
    $display("Test done: restart type %0d", t);
  endtask

  task automatic alm(input logic [1:0] a);
    int n;
    @(posedge clk);
    voltage_alarm_restart_enable <= a[0];
    restart_type <= drss_pkg::RST_NONE;
    if (a[0]) q_freq.push_back(starting_frequency);
    @(posedge clk);
    if (a[1]) overvoltage_alarm <= 1'b1;
    else undervoltage_alarm <= 1'b1;
    wait_oe(1'b0, 8, n);
    cmp_val(a[0], n < 8);
    @(posedge clk);
    undervoltage_alarm <= 1'b0;
    overvoltage_alarm <= 1'b0;
    wait_oe(1'b1, 200, n);
    cmp_val(1, !a[0] ||
            (n >= block_wait_time && n <= block_wait_time + 6));
    repeat (20) @(posedge clk);
    $display("Test done: alarm case %0d", a);
  endtask

  task automatic run_mode(input logic [2:0] m, input int n);
    int s;
    int k;
    s = 1;
    for (k = 0; k < n; k++) begin
      q_step.push_back({4'(s), sel_of(s, m), s > 5});
      s = nxt(s, m);
    end
    @(posedge clk);
    for (k = 0; k < 3; k++)
      digital_output_function_select[k] <= codes[(k + m) % 4];
    auto_mode_select <= m;
    run_cmd <= 1'b1;
    for (k = 0; k < 3000 && q_step.size() != 0; k++) @(posedge clk);
    q_step.push_back({4'h0, drss_pkg::SEL_MAIN, 1'b0});
    run_cmd <= 1'b0;
    repeat (4) @(posedge clk);
    $display("Test done: auto mode %0d", m);
  endtask

  initial begin
    seed = 32'h357cdbe0;
    {reset_n, block_pin, undervoltage_alarm, overvoltage_alarm} = 4'h0;
    {voltage_alarm_restart_enable, restart_type, auto_mode_select} = 6'h00;
    run_cmd = 1'b1;
    for (int k = 0; k < 3; k++) digital_output_function_select[k] = codes[k];
    restart_stall_level = 16'h0400 | (16'($random(seed)) & 16'h07FF);
    restart_decel_rate = 16'h0040;
    voltage_recover_rate = 16'h0100;
    target_voltage = 16'h4000;
    running_frequency = 16'h1000 | 16'($random(seed));
    starting_frequency = 16'h1000 | 16'($random(seed));
    upper_limit_frequency = 16'h1000 | 16'($random(seed));
    set_frequency = 16'h1000 | 16'($random(seed));
    block_wait_time = 32'($unsigned($random(seed)) % 31 + 10);
    jog_step_period = 32'($unsigned($random(seed)) % 3 + 1);
    preset_one_step_period = 32'($unsigned($random(seed)) % 3 + 1);
    preset_two_step_period = 32'($unsigned($random(seed)) % 3 + 1);
    preset_three_step_period = 32'($unsigned($random(seed)) % 3 + 1);
    main_or_halt_step_period = 32'($unsigned($random(seed)) % 3 + 1);
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int t = 0; t < 4; t++) blk(2'(t));
    auto_mode_select <= 3'h7;
    for (int a = 0; a < 4; a++) alm(2'(a));
    run_cmd <= 1'b0;
    run_mode(3'h1, 5);
    for (int m = 2; m < 7; m++) run_mode(3'(m), 12);
    cmp_val(0, q_freq.size() + q_step.size());
    print_verdict();
  end

  initial begin
    #80000;
    fails++;
    print_verdict();
  end
endmodule
`default_nettype wire
